// file: inc/pspb_pkg.sv
// Constants shared by the parallel slave port buffer block.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package pspb_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] PSPB_IDX_CTRL  = 12'hF60;
	localparam logic [11:0] PSPB_IDX_STAT  = 12'hF61;
	localparam logic [11:0] PSPB_IDX_IN0   = 12'hF62;
	localparam logic [11:0] PSPB_IDX_IN3   = 12'hF65;
	localparam logic [11:0] PSPB_IDX_OUT1  = 12'hF67;
	localparam logic [11:0] PSPB_IDX_OUT3  = 12'hF69;
	localparam logic [11:0] PSPB_IDX_ADDRL = 12'hF6E;

	// Control register fields
	localparam int PSPB_CTL_EN    = 0;
	localparam int PSPB_CTL_MODE  = 1;
	localparam int PSPB_CTL_INCREMENT_MODE_FIELD  = 3;
	localparam int PSPB_CTL_INTERRUPT_MODE_FIELD  = 5;
	localparam int PSPB_CTL_CSPOL = 7;
	localparam int PSPB_CTL_RDPOL = 8;
	localparam int PSPB_CTL_WRPOL = 9;
	localparam int PSPB_CTL_W     = 10;
	localparam logic [9:0] PSPB_CTRL_RST = 10'h380;

	// Status register fields
	localparam int PSPB_ST_INF  = 0;
	localparam int PSPB_ST_IN_OVERFLOW = 4;
	localparam int PSPB_ST_IBF  = 5;
	localparam int PSPB_ST_OBE  = 8;
	localparam int PSPB_ST_OUT_UNDERFLOW = 12;
	localparam int PSPB_ST_AOBE = 13;
	localparam int PSPB_ST_IRQ  = 16;

	localparam logic [3:0] PSPB_OUT_EMPTY_RST = 4'hF;
	localparam logic [3:0] PSPB_IN_FULL_RST   = 4'h0;

	localparam logic [1:0] PSPB_MODE_LEGACY = 2'h0;
	localparam logic [1:0] PSPB_MODE_ADDR   = 2'h1;
	localparam logic [1:0] PSPB_INCREMENT_MODE_FIELD_BUF    = 2'h3;
	localparam logic [1:0] PSPB_INTERRUPT_MODE_FIELD_EACH   = 2'h1;
	localparam logic [1:0] PSPB_INTERRUPT_MODE_FIELD_FOURTH = 2'h3;
	localparam logic [1:0] PSPB_LAST_BUF    = 2'h3;

	localparam logic [1:0] PSPB_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PSPB_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {PSPB_R_NONE, PSPB_R_CTRL, PSPB_R_STAT, PSPB_R_IN, PSPB_R_OUT} pspb_reg_t;

endpackage

// file: logic/pspb_sync.sv
// Two-flop synchroniser for a bundle of port pins.
// Assumes each bit is stable around the strobes that qualify it.
`timescale 1ns/1ps
module pspb_sync #(
	parameter int W = 13
) (
	input  wire logic         aclk,    // System clock
	input  wire logic         aresetn, // Synchronous reset, active low
	input  wire logic [W-1:0] d,       // Asynchronous inputs
	output logic      [W-1:0] q        // Synchronised outputs
);
	logic [W-1:0] meta_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // pspb_sync

// file: logic/pspb_top.sv
// Parallel slave port with legacy, buffered and addressable modes.
// Assumes an AXI4-Lite master on aclk and an external strobing master on the pins.
`timescale 1ns/1ps
module pspb_top
	import pspb_pkg::*;
#(
	parameter int AW = 16
) (
	input  wire logic          aclk,               // System clock, 25 MHz
	input  wire logic          aresetn,            // Synchronous reset, active low
	input  wire logic [AW-1:0] s_axi_awaddr,       // Write address
	input  wire logic          s_axi_awvalid,      // Write address valid
	output logic               s_axi_awready,      // Write address ready
	input  wire logic [31:0]   s_axi_wdata,        // Write data
	input  wire logic [3:0]    s_axi_wstrb,        // Write byte enables
	input  wire logic          s_axi_wvalid,       // Write data valid
	output logic               s_axi_wready,       // Write data ready
	output logic [1:0]         s_axi_bresp,        // Write response
	output logic               s_axi_bvalid,       // Write response valid
	input  wire logic          s_axi_bready,       // Write response ready
	input  wire logic [AW-1:0] s_axi_araddr,       // Read address
	input  wire logic          s_axi_arvalid,      // Read address valid
	output logic               s_axi_arready,      // Read address ready
	output logic [31:0]        s_axi_rdata,        // Read data
	output logic [1:0]         s_axi_rresp,        // Read response
	output logic               s_axi_rvalid,       // Read data valid
	input  wire logic          s_axi_rready,       // Read data ready
	input  wire logic [7:0]    port_data_bus_in,   // Data pins, input side
	output logic [7:0]         port_data_bus_out,  // Data pins, output side
	output logic               port_data_bus_oe,   // Data pins driven by block
	input  wire logic          port_select_in,     // Chip select pin
	input  wire logic          read_strobe_in,     // Read strobe pin
	input  wire logic          write_strobe_in,    // Write strobe pin
	input  wire logic [1:0]    slave_addr_inputs,  // Buffer address pins
	output logic               port_irq_flag,      // Sticky port event flag
	output logic               master_mode_active  // Master mode selected
);
	logic [PSPB_CTL_W-1:0] ctrl_r;
	logic [7:0]  in_buf_r [4];
	logic [7:0]  out_buf_r [4];
	logic [3:0]  in_full_r;
	logic [3:0]  out_empty_r;
	logic        in_overflow_r;
	logic        out_underflow_r;
	logic        irq_r;
	logic [1:0]  wr_ptr_r;
	logic [1:0]  rd_ptr_r;
	logic        wr_act_r;
	logic        rd_act_r;
	logic [7:0]  data_out_r;
	logic [12:0] pins_s;
	logic [7:0]  data_s;
	logic [1:0]  addr_s;
	logic        cs_a;
	logic        rd_a;
	logic        wr_a;
	logic        enable;
	logic [1:0]  mode;
	logic        slave_on;
	logic        buffered;
	logic        addressed;
	logic        enhanced;
	logic        wr_act;
	logic        rd_act;
	logic        wr_end;
	logic        rd_end;
	logic [1:0]  wr_sel;
	logic [1:0]  rd_sel;
	logic        irq_event;
	logic        all_in_full;
	logic        all_out_empty;
	logic        wr_go;
	logic        rd_go;
	pspb_reg_t   wkind;
	pspb_reg_t   rkind;
	logic [1:0]  wbuf;
	logic [1:0]  rbuf;
	logic [31:0] stat_word;

	function automatic pspb_reg_t reg_kind(input logic [AW-1:0] a);
		logic [11:0] idx;
		idx = a[13:2];
		if (a[AW-1:14] != '0)
			return PSPB_R_NONE;
		if (idx == PSPB_IDX_CTRL)
			return PSPB_R_CTRL;
		if (idx == PSPB_IDX_STAT)
			return PSPB_R_STAT;
		if (idx >= PSPB_IDX_IN0 && idx <= PSPB_IDX_IN3)
			return PSPB_R_IN;
		if (idx == PSPB_IDX_ADDRL || (idx >= PSPB_IDX_OUT1 && idx <= PSPB_IDX_OUT3))
			return PSPB_R_OUT;
		return PSPB_R_NONE;
	endfunction

	function automatic logic [1:0] buf_index(input logic [AW-1:0] a);
		logic [11:0] idx;
		idx = a[13:2];
		if (idx == PSPB_IDX_ADDRL)
			return 2'h0;
		if (idx >= PSPB_IDX_OUT1)
			return 2'(idx - PSPB_IDX_OUT1 + 12'h001);
		return 2'(idx - PSPB_IDX_IN0);
	endfunction

	pspb_sync #(
		.W (13)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({port_select_in, read_strobe_in, write_strobe_in, slave_addr_inputs, port_data_bus_in}),
		.q       (pins_s)
	);

	assign data_s = pins_s[7:0];
	assign addr_s = pins_s[9:8];

	assign cs_a = pins_s[12] ~^ ctrl_r[PSPB_CTL_CSPOL];
	assign rd_a = pins_s[11] ~^ ctrl_r[PSPB_CTL_RDPOL];
	assign wr_a = pins_s[10] ~^ ctrl_r[PSPB_CTL_WRPOL];

	assign enable    = ctrl_r[PSPB_CTL_EN];
	assign mode      = ctrl_r[PSPB_CTL_MODE +: 2];
	assign slave_on  = enable && !mode[1];
	assign buffered  = slave_on && mode == PSPB_MODE_LEGACY && ctrl_r[PSPB_CTL_INCREMENT_MODE_FIELD +: 2] == PSPB_INCREMENT_MODE_FIELD_BUF;
	assign addressed = slave_on && mode == PSPB_MODE_ADDR;
	assign enhanced  = buffered || addressed;
	assign master_mode_active = enable && mode[1];

	assign wr_act = slave_on && cs_a && wr_a;
	assign rd_act = slave_on && cs_a && rd_a;
	assign wr_end = wr_act_r && !wr_act;
	assign rd_end = rd_act_r && !rd_act;

	assign wr_sel = addressed ? addr_s : (buffered ? wr_ptr_r : 2'h0);
	assign rd_sel = addressed ? addr_s : (buffered ? rd_ptr_r : 2'h0);

	assign all_in_full   = enhanced ? &in_full_r : in_full_r[0];
	assign all_out_empty = enhanced ? &out_empty_r : out_empty_r[0];

	// interrupt per write strobe in legacy mode; per strobe or per fourth buffer in buffered or addressable mode
	always_comb
	begin
		irq_event = 1'b0;
		if (!enhanced)
			irq_event = wr_end;
		else if (ctrl_r[PSPB_CTL_INTERRUPT_MODE_FIELD +: 2] == PSPB_INTERRUPT_MODE_FIELD_EACH)
			irq_event = wr_end || rd_end;
		else if (ctrl_r[PSPB_CTL_INTERRUPT_MODE_FIELD +: 2] == PSPB_INTERRUPT_MODE_FIELD_FOURTH)
			irq_event = (wr_end && wr_sel == PSPB_LAST_BUF) || (rd_end && rd_sel == PSPB_LAST_BUF);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_act_r <= 1'b0;
			rd_act_r <= 1'b0;
		end
		else
		begin
			wr_act_r <= wr_act;
			rd_act_r <= rd_act;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !buffered)
			wr_ptr_r <= 2'h0;
		else if (wr_end)
			wr_ptr_r <= wr_ptr_r + 2'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !buffered)
			rd_ptr_r <= 2'h0;
		else if (rd_end)
			rd_ptr_r <= rd_ptr_r + 2'h1;
	end

	// byte captured at the end of the write strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				in_buf_r[i] <= 8'h00;
		end
		// byte dropped on a full buffer
		else if (wr_end && !in_full_r[wr_sel])
			in_buf_r[wr_sel] <= data_s;
	end

	// full set by strobe wins over software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			in_full_r <= PSPB_IN_FULL_RST;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (wr_end && wr_sel == 2'(i))
					in_full_r[i] <= 1'b1;
				else if (rd_go && rkind == PSPB_R_IN && rbuf == 2'(i))
					in_full_r[i] <= 1'b0;
			end
		end
	end

	// empty set on read out, cleared by software load
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_empty_r <= PSPB_OUT_EMPTY_RST;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (rd_end && rd_sel == 2'(i))
					out_empty_r[i] <= 1'b1;
				else if (wr_go && wkind == PSPB_R_OUT && wbuf == 2'(i) && s_axi_wstrb[0])
					out_empty_r[i] <= 1'b0;
			end
		end
	end

	// error flags sticky until software clears
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_overflow_r   <= 1'b0;
			out_underflow_r <= 1'b0;
			irq_r           <= 1'b0;
		end
		else
		begin
			// overflow on a write to a full buffer
			if (wr_end && in_full_r[wr_sel])
				in_overflow_r <= 1'b1;
			else if (wr_go && wkind == PSPB_R_STAT && s_axi_wstrb[0] && s_axi_wdata[PSPB_ST_IN_OVERFLOW])
				in_overflow_r <= 1'b0;
			// underflow on a read of an empty buffer, in buffered or addressable mode only
			if (rd_end && enhanced && out_empty_r[rd_sel])
				out_underflow_r <= 1'b1;
			else if (wr_go && wkind == PSPB_R_STAT && s_axi_wstrb[1] && s_axi_wdata[PSPB_ST_OUT_UNDERFLOW])
				out_underflow_r <= 1'b0;
			// interrupt flag on each irq_event
			if (irq_event)
				irq_r <= 1'b1;
			else if (wr_go && wkind == PSPB_R_STAT && s_axi_wstrb[2] && s_axi_wdata[PSPB_ST_IRQ])
				irq_r <= 1'b0;
		end
	end

	assign port_irq_flag = irq_r;

	// output byte presented while selected and reading
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			data_out_r <= 8'h00;
		else
			data_out_r <= out_buf_r[rd_sel];
	end

	assign port_data_bus_out = data_out_r;
	assign port_data_bus_oe  = rd_act;

	// Register bus: both write channels taken together
	assign wkind         = reg_kind(s_axi_awaddr);
	assign rkind         = reg_kind(s_axi_araddr);
	assign wbuf          = buf_index(s_axi_awaddr);
	assign rbuf          = buf_index(s_axi_araddr);
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= PSPB_CTRL_RST;
		else if (wr_go && wkind == PSPB_R_CTRL)
		begin
			if (s_axi_wstrb[0])
				ctrl_r[7:0] <= s_axi_wdata[7:0];
			if (s_axi_wstrb[1])
				ctrl_r[PSPB_CTL_W-1:8] <= s_axi_wdata[PSPB_CTL_W-1:8];
		end
	end

	// address low register shares output buffer 0
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				out_buf_r[i] <= 8'h00;
		end
		else if (wr_go && wkind == PSPB_R_OUT && s_axi_wstrb[0])
			out_buf_r[wbuf] <= s_axi_wdata[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PSPB_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wkind == PSPB_R_NONE) ? PSPB_RESP_SLVERR : PSPB_RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_comb
	begin
		stat_word                        = 32'h0000_0000;
		stat_word[PSPB_ST_INF +: 4]      = in_full_r;
		stat_word[PSPB_ST_IN_OVERFLOW]          = in_overflow_r;
		stat_word[PSPB_ST_IBF]           = all_in_full;
		stat_word[PSPB_ST_OBE +: 4]      = out_empty_r;
		stat_word[PSPB_ST_OUT_UNDERFLOW]          = out_underflow_r;
		stat_word[PSPB_ST_AOBE]          = all_out_empty;
		stat_word[PSPB_ST_IRQ]           = irq_r;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= PSPB_RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= PSPB_RESP_OKAY;
			unique case (rkind)
				PSPB_R_CTRL: s_axi_rdata <= {22'h000000, ctrl_r};
				PSPB_R_STAT: s_axi_rdata <= stat_word;
				PSPB_R_IN:   s_axi_rdata <= {24'h000000, in_buf_r[rbuf]};
				PSPB_R_OUT:  s_axi_rdata <= {24'h000000, out_buf_r[rbuf]};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= PSPB_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // pspb_top

// file: dv/pspb_chk.sv
// Checker for the parallel slave port block, bound to pspb_top.
// Assumes the bench keeps strobes apart and never rewrites control during a pin access.
`timescale 1ns/1ps
module pspb_chk (
	input wire logic       aclk,               // System clock
	input wire logic       aresetn,            // Synchronous reset, active low
	input wire logic       s_axi_awvalid,      // Write address valid
	input wire logic       s_axi_awready,      // Write address ready
	input wire logic       s_axi_wvalid,       // Write data valid
	input wire logic       s_axi_wready,       // Write data ready
	input wire logic       s_axi_bvalid,       // Write response valid
	input wire logic       s_axi_arvalid,      // Read address valid
	input wire logic       s_axi_arready,      // Read address ready
	input wire logic       s_axi_rvalid,       // Read data valid
	input wire logic       s_axi_rready,       // Read data ready
	input wire logic [7:0] port_data_bus_out,  // Data pins, output side
	input wire logic       port_data_bus_oe,   // Data pins driven
	input wire logic       port_select_in,     // Select pin
	input wire logic       read_strobe_in,     // Read strobe pin
	input wire logic       write_strobe_in,    // Write strobe pin
	input wire logic       port_irq_flag,      // Port event flag
	input wire logic       master_mode_active  // Master mode selected
);
	logic [2:0] pins_r;
	logic [3:0] quiet_r;

	// Cycles since any control pin last moved
	always_ff @(posedge aclk)
	begin
		pins_r <= {port_select_in, read_strobe_in, write_strobe_in};
		if (!aresetn || {port_select_in, read_strobe_in, write_strobe_in} != pins_r)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_wr_ans; s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rv_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rv_drop: assert property (p_rv_drop) else $error("read data repeated");
	property p_oe_sync; $rose(port_data_bus_oe) |-> $stable(read_strobe_in) && $stable(port_select_in); endproperty
	a_oe_sync: assert property (p_oe_sync) else $error("bus driven from unsynchronised pins");
	property p_oe_slave; port_data_bus_oe |-> !master_mode_active; endproperty
	a_oe_slave: assert property (p_oe_slave) else $error("slave drive in master mode");
	property p_mm_chg; $changed(master_mode_active) |-> $rose(s_axi_bvalid); endproperty
	a_mm_chg: assert property (p_mm_chg) else $error("master mode moved without a write");
	property p_out_hold; port_data_bus_oe && $past(port_data_bus_oe) && $past(port_data_bus_oe, 2) |-> $stable(port_data_bus_out); endproperty
	a_out_hold: assert property (p_out_hold) else $error("read data moved mid strobe");
	property p_irq_src; $rose(port_irq_flag) |-> quiet_r inside {[4'h1:4'h6]}; endproperty
	a_irq_src: assert property (p_irq_src) else $error("event flag without strobe end");
	property p_irq_clr; $fell(port_irq_flag) |-> $past(s_axi_wready) || $past(s_axi_wready, 2); endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("event flag cleared by hardware");
endmodule // pspb_chk

bind pspb_top pspb_chk pspb_chk_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_data_bus_out(port_data_bus_out),
	.port_data_bus_oe(port_data_bus_oe), .port_select_in(port_select_in), .read_strobe_in(read_strobe_in),
	.write_strobe_in(write_strobe_in), .port_irq_flag(port_irq_flag), .master_mode_active(master_mode_active));

// file: dv/pspb_pin_master.sv
// External strobing master on the port pins.
// Assumes aclk paces it; strobes held 6 cycles, idle 9 after a write and 6 after a read, data held 4 past release.
`timescale 1ns/1ps
module pspb_pin_master (
	input  wire logic       aclk,    // Pacing clock
	input  wire logic [2:0] act,     // Active levels of select, read, write
	input  wire logic [7:0] dev_out, // Data from the device
	input  wire logic       dev_oe,  // Device drives the data pins
	output logic      [7:0] din,     // Resolved data pin level
	output logic            cs_pin,  // Select pin
	output logic            rd_pin,  // Read strobe pin
	output logic            wr_pin,  // Write strobe pin
	output logic      [1:0] addr     // Buffer address pins
);
	logic [7:0] drv = 8'h00;
	logic       drv_en = 1'h0;
	logic       sel = 1'h0;
	logic       rd = 1'h0;
	logic       wr = 1'h0;

	initial addr = 2'h0;
	assign cs_pin = sel ~^ act[2];
	assign rd_pin = rd ~^ act[1];
	assign wr_pin = wr ~^ act[0];
	assign din = dev_oe ? dev_out : (drv_en ? drv : ~drv);

	task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
		@(posedge aclk);
		addr <= a; drv <= d; drv_en <= 1'h1; sel <= 1'h1; wr <= 1'h1;
		repeat (6) @(posedge aclk);
		sel <= 1'h0; wr <= 1'h0;
		repeat (4) @(posedge aclk);
		drv_en <= 1'h0;
		repeat (5) @(posedge aclk);
	endtask

	task automatic rd_byte(input logic [1:0] a, output logic [7:0] q);
		@(posedge aclk);
		addr <= a; sel <= 1'h1; rd <= 1'h1;
		repeat (6) @(posedge aclk);
		q = dev_out;
		sel <= 1'h0; rd <= 1'h0;
		repeat (6) @(posedge aclk);
	endtask
endmodule // pspb_pin_master

// file: dv/pspb_top_tb.sv
// Self-checking bench for the parallel slave port block.
// Registers over AXI4-Lite from here; pins through the pin master model.
`timescale 1ns/1ps
module pspb_top_tb
	import pspb_pkg::*;
;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, oe, cs_pin, rd_pin, wr_pin, irq, mm;
	logic [1:0]  bresp, rresp, pin_addr, rs;
	logic [7:0]  dout, din, b;
	logic [2:0]  act = 3'h7;
	int          error_cnt = 0, checked = 0, i;

	always #20 aclk = ~aclk;

	pspb_top pspb_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_data_bus_in(din),
		.port_data_bus_out(dout), .port_data_bus_oe(oe), .port_select_in(cs_pin), .read_strobe_in(rd_pin),
		.write_strobe_in(wr_pin), .slave_addr_inputs(pin_addr), .port_irq_flag(irq), .master_mode_active(mm));
	pspb_pin_master pm (.aclk(aclk), .act(act), .dev_out(dout), .dev_oe(oe), .din(din), .cs_pin(cs_pin),
		.rd_pin(rd_pin), .wr_pin(wr_pin), .addr(pin_addr));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic acc(input logic w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] r,
		output logic [1:0] resp);
		int n;
		logic aw_t, w_t, ar_t, done;
		@(posedge aclk);
		if (w)
		begin
			awaddr <= {2'h0, idx, 2'h0}; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
		end
		else
		begin
			araddr <= {2'h0, idx, 2'h0}; arvalid <= 1'h1; rready <= 1'h1;
		end
		for (n = 0; n < 40; n++)
		begin
			// Settled values at mid cycle are what the next rising edge samples
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			ar_t = arvalid && arready;
			done = w ? (bvalid === 1'h1) : (rvalid === 1'h1);
			resp = w ? bresp : rresp;
			r = rdata;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'h0;
			if (w_t) wvalid <= 1'h0;
			if (ar_t) arvalid <= 1'h0;
			if (done)
			begin
				bready <= 1'h0;
				rready <= 1'h0;
				break;
			end
		end
		if (n == 40) error_cnt++;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		acc(1'h1, idx, d, q, rs);
	endtask

	task automatic rd(input string nm, input logic [11:0] idx, input logic [31:0] e);
		acc(1'h0, idx, 32'h0, q, rs);
		chk(nm, q, e);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		stop_test;
	end

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd("ctrl", PSPB_IDX_CTRL, 32'h380);
		rd("stat", PSPB_IDX_STAT, 32'h2F00);
		rd("addr low", PSPB_IDX_ADDRL, 32'h0);
		acc(1'h0, 12'h000, 32'h0, q, rs);
		chk("unmapped", {rs, q[29:0]}, {PSPB_RESP_SLVERR, 30'h0});
		$display("reset test done");
		wr(PSPB_IDX_CTRL, 32'h3F9);
		for (i = 0; i < 4; i++) wr(i == 0 ? PSPB_IDX_ADDRL : PSPB_IDX_OUT1 + 12'(i - 1), 32'h11 * 32'(i + 1));
		for (i = 0; i < 3; i++) pm.wr_byte(2'h0, 8'hA0 + 8'(i));
		chk("irq early", {31'h0, irq}, 32'h0);
		pm.wr_byte(2'h0, 8'hA3);
		rd("stat full", PSPB_IDX_STAT, 32'h1002F);
		pm.wr_byte(2'h0, 8'hEE);
		rd("stat ovf", PSPB_IDX_STAT, 32'h1003F);
		// software drains all four input buffers
		for (i = 0; i < 4; i++) rd("in buf", PSPB_IDX_IN0 + 12'(i), 32'hA0 + 32'(i));
		rd("stat drained", PSPB_IDX_STAT, 32'h10010);
		for (i = 0; i < 4; i++)
		begin
			pm.rd_byte(2'h0, b);
			chk("pin read", {24'h0, b}, 32'h11 * 32'(i + 1));
		end
		rd("stat empty", PSPB_IDX_STAT, 32'h12F10);
		pm.rd_byte(2'h0, b);
		rd("stat unf", PSPB_IDX_STAT, 32'h13F10);
		wr(PSPB_IDX_STAT, 32'h11010);
		rd("stat clr", PSPB_IDX_STAT, 32'h2F00);
		$display("buffered test done");
		wr(PSPB_IDX_CTRL, 32'h3A3);
		pm.wr_byte(2'h2, 8'h5A);
		chk("irq each", {31'h0, irq}, 32'h1);
		pm.wr_byte(2'h2, 8'h66);
		rd("stat addr", PSPB_IDX_STAT, 32'h12F14);
		rd("in2", PSPB_IDX_IN0 + 12'h2, 32'h5A);
		wr(PSPB_IDX_OUT3, 32'hC3);
		pm.rd_byte(2'h3, b);
		chk("addr read", {24'h0, b}, 32'hC3);
		pm.rd_byte(2'h3, b);
		rd("stat addr unf", PSPB_IDX_STAT, 32'h13F10);
		$display("addressable test done");
		wr(PSPB_IDX_STAT, 32'h11010);
		wr(PSPB_IDX_CTRL, 32'h0);
		act <= 3'h0;
		wr(PSPB_IDX_ADDRL, 32'h9C);
		wr(PSPB_IDX_CTRL, 32'h1);
		pm.wr_byte(2'h0, 8'h77);
		rd("stat legacy", PSPB_IDX_STAT, 32'h10E21);
		rd("in0 legacy", PSPB_IDX_IN0, 32'h77);
		pm.rd_byte(2'h0, b);
		chk("legacy read", {24'h0, b}, 32'h9C);
		chk("oe idle", {31'h0, oe}, 32'h0);
		$display("legacy test done");
		wr(PSPB_IDX_CTRL, 32'h380);
		act <= 3'h7;
		wr(PSPB_IDX_CTRL, 32'h385);
		chk("master on", {31'h0, mm}, 32'h1);
		wr(PSPB_IDX_CTRL, 32'h386);
		chk("master off", {31'h0, mm}, 32'h0);
		$display("master test done");
		stop_test;
	end
endmodule // pspb_top_tb
